// ---- common/vfm_consts.svh ----
`ifndef VFM_CONSTS_SVH
`define VFM_CONSTS_SVH

// register byte offsets
`define VFM_CFG_OFF       12'h000
`define VFM_STATUS_OFF    12'h004
`define VFM_WPTR0_OFF     12'h008
`define VFM_RPTR0_OFF     12'h00C
`define VFM_WPTR1_OFF     12'h010
`define VFM_RPTR1_OFF     12'h014
`define VFM_DEPTH_OFF     12'h018

// field positions and reset values
`define VFM_CFG_CODE_LSB  0
`define VFM_CFG_DIR_BIT   4
`define VFM_CODE_RST      4'h0
`define VFM_DIR_RST       1'b0
`define VFM_STAT_DUAL_BIT 8
`define VFM_STAT_WIDE_BIT 9

// organization codes
`define VFM_ORG_S8        4'b000?
`define VFM_ORG_S10       4'b0010
`define VFM_ORG_S12       4'b0011
`define VFM_ORG_S16       4'b100?
`define VFM_ORG_S20       4'b1010
`define VFM_ORG_S24       4'b1011
`define VFM_ORG_D8        4'b110?
`define VFM_ORG_D10       4'b1110
`define VFM_ORG_D12       4'b1111

// lane and pointer widths in bits
`define VFM_LANE_W        12
`define VFM_PTR_W         24
`define VFM_BITS_8        4'h8
`define VFM_BITS_10       4'hA
`define VFM_BITS_12       4'hC

// depth = multiplier * unit (unit 64,680 words)
`define VFM_DEPTH_UNIT    64680
`define VFM_MUL_S8        5'h1E
`define VFM_MUL_S10       5'h18
`define VFM_MUL_S12       5'h14
`define VFM_MUL_S16       5'h0F
`define VFM_MUL_S20       5'h0C
`define VFM_MUL_S24       5'h0A
`define VFM_MUL_D8        5'h0F
`define VFM_MUL_D10       5'h0C
`define VFM_MUL_D12       5'h0A
`define VFM_BANK_MUL      15

`endif

// ---- common/vfm_pkg.sv ----
`include "vfm_consts.svh"

package vfm_pkg;

  typedef struct packed {
    logic       dual;
    logic       wide;
    logic [3:0] lane_bits;
    logic [4:0] depth_mult;
  } vfm_mode_t;

  typedef struct packed {
    logic [`VFM_LANE_W-1:0] upper_data_lane;
    logic [`VFM_LANE_W-1:0] lower_data_lane;
  } vfm_lanes_t;

endpackage

// ---- hdl/vfm_buf2.sv ----
`timescale 1ns/1ps

module vfm_buf2 #(
  parameter int W = 24
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         clr_in,
  // fill side
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  // drain side
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);

  logic [1:0]   count_q;
  logic [W-1:0] head_q;
  logic [W-1:0] tail_q;
  logic         push;
  logic         pop;

  assign in_ready_out  = (count_q != 2'h2);
  assign out_valid_out = (count_q != 2'h0);
  assign out_data_out  = head_q;
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      count_q <= 2'h0;
    else if (clr_in)
      count_q <= 2'h0;
    else
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      head_q <= '0;
      tail_q <= '0;
    end
    else if (pop)
    begin
      // full: tail moves up; one entry: refill from input if pushing
      head_q <= (count_q == 2'h2) ? tail_q : in_data_in;
    end
    else if (push)
    begin
      if (count_q == 2'h0)
        head_q <= in_data_in;
      else
        tail_q <= in_data_in;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  buf_hold_a: assert property (out_valid_out && !out_ready_in && !clr_in |=>
    out_valid_out && $stable(out_data_out))
    else $error("buffer head changed while stalled");
  buf_count_a: assert property (push && !pop && !clr_in && count_q == 2'h1 |=> !in_ready_out)
    else $error("buffer did not report full");
  buf_full_c: cover property (count_q == 2'h2 ##1 pop);

endmodule

// ---- hdl/vfm_top.sv ----
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "vfm_consts.svh"

// Functional notes
// - code 000x: single channel, 8 bits, 1,940,400 words
// - code 0010: single channel, 10 bits, 1,552,320 words
// - code 0011: single channel, 12 bits, 1,293,600 words
// - code 100x: single channel, 16 bits, 970,200 words
// - code 1010: single channel, 20 bits, 776,160 words
// - code 1011: single channel, 24 bits, 646,800 words
// - code 110x: two channels, 8 bits, 970,200 words each
// - code 1110: two channels, 10 bits, 776,160 words each
// - code 1111: two channels, 12 bits, 646,800 words each
// - direction 0 and write force low: write pointer loaded from address port
// - direction 1 and read force low: read pointer loaded from address port
// - address port and force inputs ignored in dual-channel organizations
// - after force released, pointer counts on from last forced address
// - dual channels share the clock, reset and apb port; valid, request and ready ports and data lanes per channel
module vfm_top #(
  parameter int DEPTH_UNIT = `VFM_DEPTH_UNIT
) (
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  // apb slave
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [11:0]            paddr_in,
  input  wire logic [31:0]            pwdata_in,
  input  wire logic [3:0]             pstrb_in,
  output logic [31:0]                 prdata_out,
  output logic                        pready_out,
  output logic                        pslverr_out,
  // write ports, index is channel
  input  wire logic [1:0]             wr_valid_in,
  input  wire vfm_pkg::vfm_lanes_t    wr_lanes_in,
  // read ports, index is channel
  input  wire logic [1:0]             rd_req_in,
  output logic [1:0]                  rd_req_ready_out,
  output logic [1:0]                  rd_valid_out,
  input  wire logic [1:0]             rd_ready_in,
  output vfm_pkg::vfm_lanes_t         rd_lanes_out,
  // external address override
  input  wire logic [`VFM_PTR_W-1:0]  ext_addr_in,
  input  wire logic                   write_pointer_force_n_in,
  input  wire logic                   read_pointer_force_n_in
);
  import vfm_pkg::*;

  localparam int BANK_WORDS = `VFM_BANK_MUL * DEPTH_UNIT;
  localparam int BANK_AW    = $clog2(BANK_WORDS);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  logic [3:0]                     code_q;
  logic                           override_direction_select_q;
  vfm_mode_t                      mode;
  logic [`VFM_PTR_W-1:0]          depth;
  logic [4:0]                     word_bits;
  logic                           narrow;
  logic [1:0][`VFM_PTR_W-1:0]     wptr_q;
  logic [1:0][`VFM_PTR_W-1:0]     rptr_q;
  logic [1:0][`VFM_PTR_W-1:0]     waddr;
  logic [1:0][`VFM_PTR_W-1:0]     raddr;
  logic [1:0]                     wfire;
  logic [1:0]                     rfire;
  logic                           wforce;
  logic                           rforce;
  logic [`VFM_PTR_W-1:0]          ext_clip;
  logic [11:0]                    mask;
  logic                           cfg_wr;
  logic [31:0]                    rd_mux;
  logic                           mapped;

  function automatic vfm_mode_t vfm_decode(input logic [3:0] code);
    vfm_mode_t m;
    m = '0;
    unique casez (code)
      `VFM_ORG_S8:  m = '{1'b0, 1'b0, `VFM_BITS_8,  `VFM_MUL_S8};
      `VFM_ORG_S10: m = '{1'b0, 1'b0, `VFM_BITS_10, `VFM_MUL_S10};
      `VFM_ORG_S12: m = '{1'b0, 1'b0, `VFM_BITS_12, `VFM_MUL_S12};
      `VFM_ORG_S16: m = '{1'b0, 1'b1, `VFM_BITS_8,  `VFM_MUL_S16};
      `VFM_ORG_S20: m = '{1'b0, 1'b1, `VFM_BITS_10, `VFM_MUL_S20};
      `VFM_ORG_S24: m = '{1'b0, 1'b1, `VFM_BITS_12, `VFM_MUL_S24};
      `VFM_ORG_D8:  m = '{1'b1, 1'b0, `VFM_BITS_8,  `VFM_MUL_D8};
      `VFM_ORG_D10: m = '{1'b1, 1'b0, `VFM_BITS_10, `VFM_MUL_D10};
      `VFM_ORG_D12: m = '{1'b1, 1'b0, `VFM_BITS_12, `VFM_MUL_D12};
      // 01xx is not an organization: fall back to 8-bit single
      default:      m = '{1'b0, 1'b0, `VFM_BITS_8,  `VFM_MUL_S8};
    endcase
    return m;
  endfunction

  function automatic logic [`VFM_PTR_W-1:0] depth_of(input logic [4:0] mult);
    return `VFM_PTR_W'(int'(mult) * DEPTH_UNIT);
  endfunction

  function automatic logic [`VFM_PTR_W-1:0] inc_ptr(input logic [`VFM_PTR_W-1:0] a,
                                                    input logic [`VFM_PTR_W-1:0] d);
    return (a == d - `VFM_PTR_W'(1)) ? '0 : a + `VFM_PTR_W'(1);
  endfunction

  function automatic logic [11:0] lane_mask(input logic [3:0] bits);
    return 12'hFFF << (4'hC - bits);
  endfunction

  function automatic logic [BANK_AW-1:0] bank_idx(input logic [`VFM_PTR_W-1:0] a,
                                                  input logic                  half);
    return half ? a[BANK_AW:1] : a[BANK_AW-1:0];
  endfunction

  function automatic logic depth_is(input logic [`VFM_PTR_W-1:0] d, input longint n);
    return 64'(d) * 64'(`VFM_DEPTH_UNIT) == n * 64'(DEPTH_UNIT);
  endfunction

  // organization decode
  assign mode      = vfm_decode(code_q);
  assign depth     = depth_of(mode.depth_mult);
  assign word_bits = mode.wide ? {mode.lane_bits, 1'b0} : {1'b0, mode.lane_bits};
  assign narrow    = !mode.wide && !mode.dual;
  assign mask      = lane_mask(mode.lane_bits);
  assign ext_clip  = (ext_addr_in < depth) ? ext_addr_in : '0;

  mode_s8_a: assert property (code_q[3:1] == 3'b000 |-> !mode.dual && word_bits == 5'd8 && depth_is(depth, 1940400))
    else $error("8-bit single organization decoded wrong");
  mode_s10_a: assert property (code_q == 4'b0010 |-> !mode.dual && word_bits == 5'd10 && depth_is(depth, 1552320))
    else $error("10-bit single organization decoded wrong");
  mode_s12_a: assert property (code_q == 4'b0011 |-> !mode.dual && word_bits == 5'd12 && depth_is(depth, 1293600))
    else $error("12-bit single organization decoded wrong");
  mode_s16_a: assert property (code_q[3:1] == 3'b100 |-> !mode.dual && word_bits == 5'd16 && depth_is(depth, 970200))
    else $error("16-bit single organization decoded wrong");
  mode_s20_a: assert property (code_q == 4'b1010 |-> !mode.dual && word_bits == 5'd20 && depth_is(depth, 776160))
    else $error("20-bit single organization decoded wrong");
  mode_s24_a: assert property (code_q == 4'b1011 |-> !mode.dual && word_bits == 5'd24 && depth_is(depth, 646800))
    else $error("24-bit single organization decoded wrong");
  mode_d8_a: assert property (code_q[3:1] == 3'b110 |-> mode.dual && word_bits == 5'd8 && depth_is(depth, 970200))
    else $error("8-bit dual organization decoded wrong");
  mode_d10_a: assert property (code_q == 4'b1110 |-> mode.dual && word_bits == 5'd10 && depth_is(depth, 776160))
    else $error("10-bit dual organization decoded wrong");
  mode_d12_a: assert property (code_q == 4'b1111 |-> mode.dual && word_bits == 5'd12 && depth_is(depth, 646800))
    else $error("12-bit dual organization decoded wrong");

  // apb slave, zero wait states; read data captured in setup phase
  assign pready_out = 1'b1;
  assign cfg_wr     = psel_in && penable_in && pwrite_in && paddr_in == `VFM_CFG_OFF && pstrb_in[0];

  always_comb
  begin
    rd_mux = '0;
    mapped = 1'b1;
    unique case (paddr_in)
      `VFM_CFG_OFF:    rd_mux = {27'h0, override_direction_select_q, code_q};
      `VFM_STATUS_OFF: rd_mux = {22'h0, mode.wide, mode.dual, 3'h0, word_bits};
      `VFM_WPTR0_OFF:  rd_mux = {8'h0, wptr_q[0]};
      `VFM_RPTR0_OFF:  rd_mux = {8'h0, rptr_q[0]};
      `VFM_WPTR1_OFF:  rd_mux = {8'h0, wptr_q[1]};
      `VFM_RPTR1_OFF:  rd_mux = {8'h0, rptr_q[1]};
      `VFM_DEPTH_OFF:  rd_mux = {8'h0, depth};
      default:         mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prdata_out  <= '0;
      pslverr_out <= 1'b0;
    end
    else if (psel_in && !penable_in)
    begin
      prdata_out  <= pwrite_in ? 32'h0000_0000 : rd_mux;
      pslverr_out <= !mapped;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      code_q                      <= `VFM_CODE_RST;
      override_direction_select_q <= `VFM_DIR_RST;
    end
    else if (cfg_wr)
    begin
      code_q                      <= pwdata_in[`VFM_CFG_CODE_LSB +: 4];
      override_direction_select_q <= pwdata_in[`VFM_CFG_DIR_BIT];
    end
  end

  // write and read cycles; channel 1 only exists in dual organizations
  assign wfire[0] = wr_valid_in[0];
  assign wfire[1] = wr_valid_in[1] && mode.dual;
  assign wforce   = !mode.dual && !override_direction_select_q
                    && !write_pointer_force_n_in && wfire[0];
  assign rforce   = !mode.dual && override_direction_select_q
                    && !read_pointer_force_n_in && rfire[0];

  always_comb
  begin
    waddr[0] = wforce ? ext_clip : wptr_q[0];
    waddr[1] = wptr_q[1];
    raddr[0] = rforce ? ext_clip : rptr_q[0];
    raddr[1] = rptr_q[1];
  end

  // pointers restart at zero whenever the organization is rewritten
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
    end
    else if (cfg_wr)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (wfire[c])
          wptr_q[c] <= inc_ptr(waddr[c], depth);
        if (rfire[c])
          rptr_q[c] <= inc_ptr(raddr[c], depth);
      end
    end
  end

  wforce_load_a: assert property (wforce && !cfg_wr |=> wptr_q[0] == inc_ptr($past(ext_clip), depth))
    else $error("write pointer not loaded from address port");
  rforce_load_a: assert property (rforce && !cfg_wr |=> rptr_q[0] == inc_ptr($past(ext_clip), depth))
    else $error("read pointer not loaded from address port");
  dual_noforce_a: assert property (mode.dual && !write_pointer_force_n_in && wfire[0] && !cfg_wr
    |=> wptr_q[0] == inc_ptr($past(wptr_q[0]), depth))
    else $error("address port acted in dual organization");
  force_resume_a: assert property (wforce && !cfg_wr ##1 wfire[0] && !wforce && !cfg_wr
    |=> wptr_q[0] == inc_ptr(inc_ptr($past(ext_clip, 2), depth), depth))
    else $error("write pointer did not resume after forced address");
  chan_indep_a: assert property (mode.dual && wfire[1] && !wfire[0] && !cfg_wr
    |=> $stable(wptr_q[0]) && wptr_q[1] == inc_ptr($past(wptr_q[1]), depth))
    else $error("dual channels not independent");

  // storage: two banks of 12-bit slots, one per lane in wide and dual organizations
  logic [11:0]        bank0_q [BANK_WORDS];
  logic [11:0]        bank1_q [BANK_WORDS];
  logic               b0_we;
  logic               b1_we;
  logic [BANK_AW-1:0] b0_widx;
  logic [BANK_AW-1:0] b1_widx;
  logic [11:0]        b1_wdata;
  logic [11:0]        r0;
  logic [11:0]        r1;
  vfm_lanes_t         buf0_in;
  vfm_lanes_t         buf0_out;
  logic [11:0]        buf1_out;
  logic [1:0]         buf_in_ready;
  logic [1:0]         buf_out_valid;

  // narrow single words alternate between banks on pointer bit 0
  assign b0_we    = wfire[0] && (!narrow || !waddr[0][0]);
  assign b0_widx  = bank_idx(waddr[0], narrow);
  assign b1_we    = narrow ? (wfire[0] && waddr[0][0]) : (mode.dual ? wfire[1] : wfire[0]);
  assign b1_widx  = mode.dual ? bank_idx(waddr[1], 1'b0) : bank_idx(waddr[0], narrow);
  assign b1_wdata = (narrow ? wr_lanes_in.lower_data_lane
                            : wr_lanes_in.upper_data_lane) & mask;

  always_ff @(posedge clk_in)
  begin
    if (b0_we)
      bank0_q[b0_widx] <= wr_lanes_in.lower_data_lane & mask;
  end

  always_ff @(posedge clk_in)
  begin
    if (b1_we)
      bank1_q[b1_widx] <= b1_wdata;
  end

  assign r0 = bank0_q[bank_idx(raddr[0], narrow)];
  assign r1 = bank1_q[mode.dual ? bank_idx(raddr[1], 1'b0) : bank_idx(raddr[0], narrow)];

  always_comb
  begin
    buf0_in = '0;
    if (narrow)
      buf0_in.lower_data_lane = raddr[0][0] ? r1 : r0;
    else if (mode.wide)
    begin
      buf0_in.lower_data_lane = r0;
      buf0_in.upper_data_lane = r1;
    end
    else
      buf0_in.lower_data_lane = r0;
  end

  // read requests are taken only while the output buffer has room
  assign rfire[0] = rd_req_in[0] && buf_in_ready[0];
  assign rfire[1] = rd_req_in[1] && buf_in_ready[1] && mode.dual;

  vfm_buf2 #(
    .W             (2 * `VFM_LANE_W)
  ) u_buf0 (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .clr_in        (cfg_wr),
    .in_valid_in   (rfire[0]),
    .in_ready_out  (buf_in_ready[0]),
    .in_data_in    (buf0_in),
    .out_valid_out (buf_out_valid[0]),
    .out_ready_in  (rd_ready_in[0]),
    .out_data_out  (buf0_out)
  );

  vfm_buf2 #(
    .W             (`VFM_LANE_W)
  ) u_buf1 (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .clr_in        (cfg_wr),
    .in_valid_in   (rfire[1]),
    .in_ready_out  (buf_in_ready[1]),
    .in_data_in    (r1),
    .out_valid_out (buf_out_valid[1]),
    .out_ready_in  (rd_ready_in[1] && mode.dual),
    .out_data_out  (buf1_out)
  );

  // dual: channel 1 drives the upper lane
  assign rd_req_ready_out = {buf_in_ready[1] && mode.dual, buf_in_ready[0]};
  assign rd_valid_out     = {buf_out_valid[1] && mode.dual, buf_out_valid[0]};
  assign rd_lanes_out.lower_data_lane = buf0_out.lower_data_lane;
  assign rd_lanes_out.upper_data_lane = mode.dual ? buf1_out : buf0_out.upper_data_lane;

  lane_narrow_a: assert property (rd_valid_out[0] && narrow |->
    rd_lanes_out.upper_data_lane == 12'h000 && (rd_lanes_out.lower_data_lane & ~mask) == 12'h000)
    else $error("narrow word not on lower lane msb-aligned");
  lane_wide_a: assert property (rd_valid_out[0] && mode.wide |->
    (rd_lanes_out.lower_data_lane & ~mask) == 12'h000
    && (rd_lanes_out.upper_data_lane & ~mask) == 12'h000)
    else $error("wide word halves not msb-aligned");

  wforce_c: cover property (wforce ##1 wfire[0] && !wforce);
  rforce_c: cover property (rforce ##1 rd_valid_out[0]);
  dual_rd_c: cover property (mode.dual && rfire[0] && rfire[1]);
  stall_c: cover property (rd_req_in[0] && !rd_req_ready_out[0]);

endmodule

// ---- dv/vfm_sink.sv ----
`timescale 1ns/1ps

module vfm_sink (
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  // bench control
  input  wire logic                 stall_in,
  // fifo read side
  input  wire logic [1:0]           rd_valid_in,
  input  wire vfm_pkg::vfm_lanes_t  rd_lanes_in,
  output logic [1:0]                rd_ready_out,
  // captured words
  output logic [7:0]                got_count_out,
  output vfm_pkg::vfm_lanes_t       got_lanes_out
);
  import vfm_pkg::*;

  // one ready per channel, both held off while stalling
  assign rd_ready_out = stall_in ? 2'b00 : 2'b11;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      got_count_out <= 8'h00;
      got_lanes_out <= '0;
    end
    else if ((rd_valid_in & rd_ready_out) != 2'b00)
    begin
      got_count_out <= got_count_out + 8'h01;
      got_lanes_out <= rd_lanes_in;
    end
  end
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/1ps

module testbench;
  import vfm_pkg::*;

  // code, width, {wide,dual}, depth at unit 4, lane mask
  localparam logic [55:0] ROWS [12] = '{
    56'h0080007800_0FF0, 56'h1080007800_0FF0, 56'h20A0006000_0FFC,
    56'h30C0005000_0FFF, 56'h810200_3CFF0FF0, 56'h910200_3CFF0FF0,
    56'hA14200_30FFCFFC, 56'hB18200_28FFFFFF, 56'hC08100_3CFF0FF0,
    56'hD08100_3CFF0FF0, 56'hE0A100_30FFCFFC, 56'hF0C100_28FFFFFF};

  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  wr_valid = 2'b00;
  vfm_lanes_t  wr_lanes = '0;
  logic [1:0]  rd_req = 2'b00;
  logic [1:0]  rd_req_ready;
  logic [1:0]  rd_valid;
  logic [1:0]  rd_ready;
  vfm_lanes_t  rd_lanes;
  logic [23:0] ext_addr = 24'h0;
  logic        wfn = 1'b1;
  logic        rfn = 1'b1;
  logic        stall = 1'b0;
  logic [7:0]  got_count;
  vfm_lanes_t  got_lanes;
  logic [31:0] rdata;
  logic        err;
  int          mismatches = 0;
  int          check_count = 0;
  int          cycles = 0;

  always #2.5 clk_in = ~clk_in;

  vfm_top #(.DEPTH_UNIT(4)) u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hF),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .wr_valid_in(wr_valid), .wr_lanes_in(wr_lanes), .rd_req_in(rd_req),
    .rd_req_ready_out(rd_req_ready), .rd_valid_out(rd_valid), .rd_ready_in(rd_ready),
    .rd_lanes_out(rd_lanes), .ext_addr_in(ext_addr),
    .write_pointer_force_n_in(wfn), .read_pointer_force_n_in(rfn));

  vfm_sink u_sink (
    .clk_in(clk_in), .rst_in(rst_in), .stall_in(stall), .rd_valid_in(rd_valid),
    .rd_lanes_in(rd_lanes), .rd_ready_out(rd_ready), .got_count_out(got_count),
    .got_lanes_out(got_lanes));

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge clk_in);
      n++;
    end
    if (n == 50)
      mismatches++;
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // called just after an edge; one write per call, m of 00 idles the port
  task automatic wr(input logic [1:0] m, input logic [23:0] d, input logic f_n,
                    input logic [23:0] a);
    wr_valid <= m;
    wr_lanes <= vfm_lanes_t'(d);
    wfn <= f_n;
    ext_addr <= a;
    @(posedge clk_in);
  endtask

  task automatic rd(input logic [1:0] m, input logic f_n, input logic [23:0] a,
                    output logic [23:0] q);
    logic [7:0] c0;
    int         n;
    c0 = got_count;
    n = 0;
    @(posedge clk_in);
    rd_req <= m;
    rfn <= f_n;
    ext_addr <= a;
    @(posedge clk_in);
    rd_req <= 2'b00;
    rfn <= 1'b1;
    while (got_count === c0 && n < 20)
    begin
      @(posedge clk_in);
      n++;
    end
    if (n == 20)
      mismatches++;
    q = got_lanes;
  endtask

  // hang guard
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      results();
    end
  end

  initial
  begin
    logic [23:0] q;
    logic [55:0] r;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    check("req ready after reset", {30'h0, rd_req_ready}, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    check("cfg after reset", rdata, 32'h0);
    foreach (ROWS[i])
    begin
      r = ROWS[i];
      apb(1'b1, 12'h000, {28'h0, r[55:52]});
      apb(1'b0, 12'h004, 32'h0);
      check("status", rdata, {22'h0, r[41:40], 3'h0, r[48:44]}); // to
      apb(1'b0, 12'h018, 32'h0);
      check("depth", rdata, {16'h0, r[39:24]}); // to
      wr(r[40] ? 2'b11 : 2'b01, 24'hABCDEF, 1'b1, 24'h0);
      wr(2'b00, 24'h0, 1'b1, 24'h0);
      rd(r[40] ? 2'b11 : 2'b01, 1'b1, 24'h0, q);
      check("lanes", {8'h0, q}, {8'h0, 24'hABCDEF & r[23:0]});
    end
    // forced write then back-to-back sequential write, forced read then sequential read
    apb(1'b1, 12'h000, 32'h3);
    wr(2'b01, 24'h000123, 1'b0, 24'h000005);
    wr(2'b01, 24'h000456, 1'b1, 24'h0);
    wr(2'b00, 24'h0, 1'b1, 24'h0);
    apb(1'b0, 12'h008, 32'h0);
    check("forced wptr", rdata, 32'h7);
    apb(1'b1, 12'h000, 32'h13);
    rd(2'b01, 1'b0, 24'h000005, q);
    check("forced read", {8'h0, q}, 32'h123);
    rd(2'b01, 1'b1, 24'h0, q);
    check("resumed read", {8'h0, q}, 32'h456);
    // force ignored with two channels
    apb(1'b1, 12'h000, 32'hF);
    wr(2'b11, 24'h789ABC, 1'b0, 24'h000009);
    wr(2'b00, 24'h0, 1'b1, 24'h0);
    apb(1'b0, 12'h008, 32'h0);
    check("dual wptr", rdata, 32'h1);
    // fill read buffer with consumer stalled
    apb(1'b1, 12'h000, 32'h3);
    @(posedge clk_in);
    stall <= 1'b1;
    rd_req <= 2'b01;
    repeat (4) @(posedge clk_in);
    check("req ready when full", {31'h0, rd_req_ready[0]}, 32'h0);
    check("valid when full", {31'h0, rd_valid[0]}, 32'h1);
    rd_req <= 2'b00;
    stall <= 1'b0;
    repeat (4) @(posedge clk_in);
    check("valid drained", {30'h0, rd_valid}, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    check("rptr after refusal", rdata, 32'h2);
    // reset in mid-run from a dual organization
    apb(1'b1, 12'h000, 32'hF);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    check("req ready after mid reset", {30'h0, rd_req_ready}, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    check("status after mid reset", rdata, 32'h8);
    // unmapped address
    apb(1'b0, 12'h040, 32'h0);
    check("slverr unmapped", {31'h0, err}, 32'h1);
    check("rdata unmapped", rdata, 32'h0);
    results();
  end
endmodule
